// >>> dv/host.sv
// Controller model: strap pins, cable line and register writes
`timescale 1ns/1ps
module host
  import redriver_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic power_good, // Supply good
  input wire logic [7:0] reg_rd_data, // Read data
  output logic cable_present_n, // Cable
  output logic serial_config_select, // Mode
  output logic [1:0] output_level_code, // Swing
  output logic [1:0] dc_gain_code, // Gain
  output logic [3:0] boost_code, // Boost
  output logic reg_wr_en, // Strobe
  output logic [REG_ADDR_W-1:0] reg_addr, // Address
  output logic [7:0] reg_wr_data // Data
);
  initial
  begin
    {cable_present_n, serial_config_select, boost_code, dc_gain_code, output_level_code} = 10'h200;
    {reg_wr_en, reg_addr, reg_wr_data} = 12'h000;
  end
  task automatic pins(input logic sel, input logic [7:0] p);
    @(posedge ref_clk) #1 {serial_config_select, boost_code, dc_gain_code, output_level_code} = {sel, p};
  endtask
  task automatic write_byte(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1 {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
    // Released data turns over so a stale byte never looks fresh
    @(posedge ref_clk) #1 {reg_wr_en, reg_wr_data} = {1'b0, ~d};
  endtask
  task automatic read_byte(input logic [REG_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1 reg_addr = a;
    @(posedge ref_clk) #1 d = reg_rd_data;
  endtask
  task automatic set_cable(input logic absent, input int hold);
    wait (power_good === 1'b1);
    @(posedge ref_clk) #1 cable_present_n = absent;
    repeat (hold) @(posedge ref_clk) #1;
  endtask
endmodule // host

// >>> dv/redriver_checker_assertions.sv
// Assertion checker of the redriver control outputs
`timescale 1ns/1ps
module redriver_checker
  import redriver_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic reset, // Reset
  input wire logic cable_present_n, // Cable
  input wire logic serial_config_select, // Mode
  input wire logic [1:0] output_level_code, // Swing
  input wire logic [3:0] boost_code, // Boost
  input wire lane_cfg_t lane_cfg [NUM_LANES], // Codes
  input wire lane_setting_t lane_setting [NUM_LANES], // Decoded
  input wire logic [NUM_LANES-1:0] lane_power_down, // Down
  input wire logic [NUM_LANES-1:0] lane_out_hiz, // Hi-Z
  input wire logic [6:0] target_addr, // Address
  input wire logic target_enable // Target on
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Pins pass two sync flops, so five steady samples are needed first
  a_hiz_tracks_pd: assert property (lane_out_hiz == lane_power_down)
    else $error("hiz mismatch");
  a_absent_all_down: assert property (cable_present_n [*5] |-> lane_power_down == 4'hf)
    else $error("lane awake");
  a_strap_level: assert property ((!serial_config_select && !cable_present_n
    && $stable(output_level_code)) [*5] |-> lane_cfg[3].level == output_level_code)
    else $error("strap swing");
  a_swing_decode: assert property (!$past(reset) && !$past(reset, 2)
    |-> lane_setting[0].swing_mv == 10'd700 + 10'd100 * lane_cfg[0].level)
    else $error("swing decode");
  a_gain_decode: assert property (!$past(reset) && !$past(reset, 2)
    |-> int'(lane_setting[2].gain_db) == 2 * int'(lane_cfg[2].gain) - 4)
    else $error("gain decode");
  a_boost_bottom: assert property (!$past(reset) && !$past(reset, 2)
    && lane_cfg[1].boost == 4'h0 |-> lane_setting[1].boost_tenth_db == 7'd33)
    else $error("boost decode");
  a_target_addr: assert property ((serial_config_select && $stable(boost_code)) [*5]
    |-> target_addr == {3'h7, boost_code})
    else $error("address");
  a_target_on: assert property (serial_config_select [*5] |-> target_enable)
    else $error("target off");
endmodule // redriver_checker

// >>> dv/testbench.sv
// Self-checking bench of the redriver control block
`timescale 1ns/1ps
module testbench;
  import redriver_pkg::*;
  typedef struct packed {logic [7:0] pins; logic [6:0] tenth;} row_t;
  // Pins {boost, gain, level} beside boost in tenths of dB
  row_t rows [16] = '{'{8'h00,7'd33}, '{8'h11,7'd38}, '{8'h22,7'd43}, '{8'h33,7'd48},
    '{8'h44,7'd54}, '{8'h55,7'd58}, '{8'h66,7'd63}, '{8'h77,7'd68}, '{8'h88,7'd72},
    '{8'h99,7'd77}, '{8'haa,7'd81}, '{8'hbb,7'd85}, '{8'hcc,7'd89}, '{8'hdd,7'd92},
    '{8'hee,7'd96}, '{8'hff,7'd99}};
  logic ref_clk = 1'b0, reset = 1'b1;
  wire power_good = ~reset;
  logic cable_present_n, serial_config_select, reg_wr_en, target_enable, absent_time_met;
  logic [1:0] output_level_code, dc_gain_code;
  logic [3:0] boost_code, lane_power_down, lane_out_hiz;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, b;
  logic [6:0] target_addr;
  lane_cfg_t lane_cfg [NUM_LANES];
  lane_setting_t lane_setting [NUM_LANES];
  int fail_count = 0, n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  redriver_ctrl redriver_ctrl_i (
    .ref_clk(ref_clk), .reset(reset), .cable_present_n(cable_present_n),
    .serial_config_select(serial_config_select), .output_level_code(output_level_code),
    .dc_gain_code(dc_gain_code), .boost_code(boost_code), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .target_addr(target_addr), .target_enable(target_enable), .lane_cfg(lane_cfg),
    .lane_setting(lane_setting), .lane_power_down(lane_power_down),
    .lane_out_hiz(lane_out_hiz), .absent_time_met(absent_time_met)
  );
  host host_i (
    .ref_clk(ref_clk), .power_good(power_good), .reg_rd_data(reg_rd_data),
    .cable_present_n(cable_present_n), .serial_config_select(serial_config_select),
    .output_level_code(output_level_code), .dc_gain_code(dc_gain_code),
    .boost_code(boost_code), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    for (int cycles = 0; cycles < 5000; cycles++)
      @(posedge ref_clk);
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk) #1;
    reset = 1'b0;
    @(posedge ref_clk) #1;
    chk({lane_power_down, lane_cfg[0], absent_time_met}, 13'h1e00);
    host_i.set_cable(1'b0, 0);
    foreach (rows[k])
    begin
      host_i.pins(1'b0, rows[k].pins);
      repeat (4) @(posedge ref_clk) #1;
      for (int l = 0; l < NUM_LANES; l++)
      begin
        chk({lane_cfg[l], lane_power_down[l]}, {rows[k].pins, 1'b0});
        chk(lane_setting[l], {rows[k].tenth, 4'(2 * rows[k].pins[3:2] - 4),
          10'(700 + 100 * rows[k].pins[1:0])});
      end
    end
    chk({target_enable, target_addr}, 8'h7f);
    host_i.pins(1'b1, 8'h5a);
    // Mode must pass the pin synchroniser before writes count
    repeat (2) @(posedge ref_clk) #1;
    for (int l = 0; l < NUM_LANES; l++)
      host_i.write_byte(3'(3 + l), 8'(8'h1b + 8'h44 * l));
    host_i.write_byte(3'h7, 8'hff);
    host_i.write_byte(3'h2, 8'h50);
    for (int l = 3; l < 8; l++)
    begin
      host_i.read_byte(3'(l), b);
      chk(b, l < 7 ? 8'(8'h1b + 8'h44 * (l - 3)) : 8'h00);
    end
    chk({lane_cfg[0], lane_cfg[1], lane_cfg[2], lane_cfg[3]}, 32'h1b5fa3e7);
    chk({target_enable, target_addr, lane_power_down}, 12'hf55);
    host_i.pins(1'b1, 8'h51);
    repeat (4) @(posedge ref_clk) #1;
    host_i.pins(1'b1, 8'h5a);
    host_i.read_byte(3'h4, b);
    chk({b, lane_cfg[1], lane_power_down}, 20'h00000);
    host_i.set_cable(1'b1, 990);
    chk({absent_time_met, lane_out_hiz}, 5'h0f);
    host_i.set_cable(1'b1, 30);
    chk(absent_time_met, 1'b1);
    host_i.set_cable(1'b0, 4);
    host_i.write_byte(3'h3, 8'hf7);
    repeat (3) @(posedge ref_clk) #1;
    chk({lane_cfg[0], lane_power_down}, 12'hf70);
    // Mid-run reset: registers and outputs back to defaults
    reset = 1'b1;
    @(posedge ref_clk) #1;
    chk({lane_power_down, lane_cfg[0], target_enable, target_addr, absent_time_met,
      reg_rd_data}, 29'h1e000000);
    reset = 1'b0;
    host_i.read_byte(3'h3, b);
    chk(b, 8'h00);
    repeat (2) @(posedge ref_clk) #1;
    chk({lane_power_down, lane_cfg[0]}, 12'h000);
    complete_run();
  end
endmodule // testbench
bind redriver_ctrl redriver_checker redriver_checker_i (
  .ref_clk(ref_clk), .reset(reset), .cable_present_n(cable_present_n),
  .serial_config_select(serial_config_select), .output_level_code(output_level_code),
  .boost_code(boost_code), .lane_cfg(lane_cfg), .lane_setting(lane_setting),
  .lane_power_down(lane_power_down), .lane_out_hiz(lane_out_hiz),
  .target_addr(target_addr), .target_enable(target_enable)
);

// >>> rtl/config_reg_file.sv
// Byte-wide configuration register file with registered read port
`timescale 1ns/1ps
module config_reg_file
  import redriver_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic clear, // Return all bytes to defaults
  input wire logic wr_en, // Write strobe
  input wire logic [REG_ADDR_W-1:0] addr, // Byte address
  input wire logic [7:0] wr_data, // Write data
  output logic [7:0] rd_data, // Registered read data
  output logic [7:0] power_down_byte, // Power-down byte contents
  output lane_cfg_t lane_byte [NUM_LANES] // Per-lane config bytes
);

  logic [7:0] mem [8];
  logic [7:0] next_mem [8];
  logic [7:0] next_rd_data;

  // Bytes outside the map are reserved and read as zero
  function automatic logic mapped(input logic [REG_ADDR_W-1:0] a);
    return (a >= POWER_DOWN_OFFSET) && (a <= LANE3_CFG_OFFSET);
  endfunction

  always_comb
  begin
    next_mem = mem;
    if (clear)
    begin
      for (int i = 0; i < 8; i++)
        next_mem[i] = REG_RESET_VALUE;
    end
    else if (wr_en && mapped(addr))
    begin
      next_mem[addr] = wr_data;
    end
    next_rd_data = mapped(addr) ? mem[addr] : 8'h00;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 8; i++)
        mem[i] <= REG_RESET_VALUE;
      rd_data <= 8'h00;
    end
    else
    begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end

  assign power_down_byte = mem[POWER_DOWN_OFFSET];

  always_comb
  begin
    for (int l = 0; l < NUM_LANES; l++)
      lane_byte[l] = lane_cfg_t'(mem[LANE0_CFG_OFFSET + 3'(l)]);
  end

endmodule // config_reg_file

// >>> rtl/redriver_ctrl.sv
// Configuration source selection and power control of a four-lane redriver
`timescale 1ns/1ps
module redriver_ctrl
  import redriver_pkg::*;
(
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic cable_present_n, // Pin: high means no cable
  input wire logic serial_config_select, // Pin: high selects registers
  input wire logic [1:0] output_level_code, // Pins: strap swing code
  input wire logic [1:0] dc_gain_code, // Pins: strap gain; bit 1 doubles as reset
  input wire logic [3:0] boost_code, // Pins: strap boost or address bits
  input wire logic reg_wr_en, // Register write strobe from serial engine
  input wire logic [REG_ADDR_W-1:0] reg_addr, // Register byte address
  input wire logic [7:0] reg_wr_data, // Register write data
  output logic [7:0] reg_rd_data, // Registered read data
  output logic [6:0] target_addr, // Serial target address
  output logic target_enable, // Serial target answers
  output lane_cfg_t lane_cfg [NUM_LANES], // Selected raw codes per lane
  output lane_setting_t lane_setting [NUM_LANES], // Decoded settings per lane
  output logic [NUM_LANES-1:0] lane_power_down, // Lane powered down
  output logic [NUM_LANES-1:0] lane_out_hiz, // Lane outputs high impedance
  output logic absent_time_met // Cable absent long enough for clean reset
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam int PIN_W = 10;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] next_pin_meta;
  logic [PIN_W-1:0] next_pin_sync;

  always_comb
  begin
    next_pin_meta = {cable_present_n, serial_config_select, output_level_code,
                     dc_gain_code, boost_code};
    next_pin_sync = pin_meta;
  end

  // Pull-ups on every pin, so the idle value is all ones
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin_meta <= '1;
      pin_sync <= '1;
    end
    else
    begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  logic absent;
  logic reg_mode;
  logic [1:0] s_level;
  logic [1:0] s_gain;
  logic [3:0] s_boost;
  logic config_reset_n;

  assign absent = pin_sync[9];
  assign reg_mode = pin_sync[8];
  assign s_level = pin_sync[7:6];
  assign s_gain = pin_sync[5:4];
  assign s_boost = pin_sync[3:0];
  // Shared pin acts as register reset only when registers are in use
  assign config_reset_n = reg_mode ? s_gain[1] : 1'b1;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] power_down_byte;
  lane_cfg_t lane_byte [NUM_LANES];
  logic reg_clear;

  // Register contents are lost while the cable is absent; host must rewrite
  assign reg_clear = !config_reset_n || absent;

  config_reg_file u_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(reg_clear),
    .wr_en(reg_wr_en && reg_mode),
    .addr(reg_addr),
    .wr_data(reg_wr_data),
    .rd_data(reg_rd_data),
    .power_down_byte(power_down_byte),
    .lane_byte(lane_byte)
  );

  // --------------------------------------------------------------------------
  // Decoders
  // --------------------------------------------------------------------------
  function automatic logic [9:0] swing_mv(input logic [1:0] code);
    case (code)
      2'h0: return 10'd700;
      2'h1: return 10'd800;
      2'h2: return 10'd900;
      default: return 10'd1000;
    endcase
  endfunction

  function automatic logic signed [3:0] gain_db(input logic [1:0] code);
    case (code)
      2'h0: return -4'sd4;
      2'h1: return -4'sd2;
      2'h2: return 4'sd0;
      default: return 4'sd2;
    endcase
  endfunction

  // Boost in tenths of a dB; steps are uneven so a table is used
  function automatic logic [6:0] boost_tenth_db(input logic [3:0] code);
    case (code)
      4'h0: return 7'd33;
      4'h1: return 7'd38;
      4'h2: return 7'd43;
      4'h3: return 7'd48;
      4'h4: return 7'd54;
      4'h5: return 7'd58;
      4'h6: return 7'd63;
      4'h7: return 7'd68;
      4'h8: return 7'd72;
      4'h9: return 7'd77;
      4'ha: return 7'd81;
      4'hb: return 7'd85;
      4'hc: return 7'd89;
      4'hd: return 7'd92;
      4'he: return 7'd96;
      default: return 7'd99;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Lane control outputs
  // --------------------------------------------------------------------------
  lane_cfg_t next_lane_cfg [NUM_LANES];
  lane_setting_t next_lane_setting [NUM_LANES];
  logic [NUM_LANES-1:0] next_lane_power_down;
  logic [6:0] next_target_addr;
  logic next_target_enable;
  lane_cfg_t strap_cfg;

  always_comb
  begin
    strap_cfg.boost = s_boost;
    strap_cfg.gain = s_gain;
    strap_cfg.level = s_level;
    for (int l = 0; l < NUM_LANES; l++)
    begin
      next_lane_cfg[l] = reg_mode ? lane_byte[l] : strap_cfg;
      next_lane_setting[l].swing_mv = swing_mv(next_lane_cfg[l].level);
      next_lane_setting[l].gain_db = gain_db(next_lane_cfg[l].gain);
      next_lane_setting[l].boost_tenth_db = boost_tenth_db(next_lane_cfg[l].boost);
      // Pin always wins; register bits add power-down in register mode
      next_lane_power_down[l] = absent
        || (reg_mode && power_down_byte[PD_LANE0_BIT + l]);
    end
    next_target_addr = {TARGET_ADDR_HIGH, s_boost};
    next_target_enable = reg_mode;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int l = 0; l < NUM_LANES; l++)
      begin
        lane_cfg[l] <= '0;
        lane_setting[l] <= '0;
      end
      lane_power_down <= '1;
      target_addr <= '0;
      target_enable <= 1'b0;
    end
    else
    begin
      lane_cfg <= next_lane_cfg;
      lane_setting <= next_lane_setting;
      lane_power_down <= next_lane_power_down;
      target_addr <= next_target_addr;
      target_enable <= next_target_enable;
    end
  end

  assign lane_out_hiz = lane_power_down;

  // --------------------------------------------------------------------------
  // Absent-time monitor
  // --------------------------------------------------------------------------
  // Reports only; the device cannot enforce the controller's hold time
  localparam int ABS_W = $clog2(MIN_ABSENT_CYCLES + 1);
  logic [ABS_W-1:0] absent_count;
  logic [ABS_W-1:0] next_absent_count;
  logic next_absent_time_met;

  always_comb
  begin
    next_absent_count = absent_count;
    if (!absent)
      next_absent_count = '0;
    else if (absent_count != ABS_W'(MIN_ABSENT_CYCLES))
      next_absent_count = absent_count + 1'b1;
    next_absent_time_met = absent && (next_absent_count == ABS_W'(MIN_ABSENT_CYCLES));
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      absent_count <= '0;
      absent_time_met <= 1'b0;
    end
    else
    begin
      absent_count <= next_absent_count;
      absent_time_met <= next_absent_time_met;
    end
  end

endmodule // redriver_ctrl

// >>> rtl/redriver_pkg.sv
// Shared constants and types of the redriver configuration and power control
package redriver_pkg;

  localparam int NUM_LANES = 4;
  localparam int REG_ADDR_W = 3;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [2:0] POWER_DOWN_OFFSET = 3'h2;
  localparam logic [2:0] LANE0_CFG_OFFSET = 3'h3;
  localparam logic [2:0] LANE3_CFG_OFFSET = 3'h6;
  localparam int PD_LANE0_BIT = 4;
  localparam int BOOST_MSB = 7;
  localparam int BOOST_LSB = 4;
  localparam int GAIN_MSB = 3;
  localparam int GAIN_LSB = 2;
  localparam int LEVEL_MSB = 1;
  localparam int LEVEL_LSB = 0;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // Upper address bits are fixed; lower four come from the boost pins
  localparam logic [2:0] TARGET_ADDR_HIGH = 3'h7;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int MIN_ABSENT_TIME_US = 100;
  localparam int MIN_ABSENT_CYCLES = (MIN_ABSENT_TIME_US * (REF_CLK_HZ / 1_000_000));

  typedef struct packed {
    logic [3:0] boost;
    logic [1:0] gain;
    logic [1:0] level;
  } lane_cfg_t;

  typedef struct packed {
    logic [6:0] boost_tenth_db;
    logic signed [3:0] gain_db;
    logic [9:0] swing_mv;
  } lane_setting_t;

endpackage
